// File: rtl/charge_seq.v
// Charge cycle sequencer with AXI4-Lite register access.
// Comparator results arrive as asynchronous digital flags and are synchronised here;
// the analog loop reads the current and path outputs.
`default_nettype none
`include "charge_seq_regs.vh"

module charge_seq #(
	parameter [24:0] SEC_CYCLES      = `SEC_CYCLES,
	parameter [15:0] TERM_FILTER_CYC = `TERM_FILTER_CYC
) (
	input  wire        clock,
	input  wire        reset,
	input  wire        clock_enable,
	input  wire        adapter_supply_in,
	input  wire        usb_supply_in,
	input  wire        adapter_above_cell,
	input  wire        usb_above_cell,
	input  wire        adapter_current_set_pin,
	input  wire        adapter_set_floating,
	input  wire        usb_rate_select_pin,
	input  wire        usb_rate_floating,
	input  wire        safety_timer_enable_n,
	input  wire        cell_present,
	input  wire        cell_below_precond,
	input  wire        cell_at_regulation,
	input  wire        cell_below_recharge,
	input  wire        current_below_term,
	input  wire        die_over_temp,
	input  wire        die_cooled,
	input  wire        cell_temp_sense,
	input  wire        system_test_req,
	output reg         adapter_path_on,
	output reg         usb_path_on,
	output reg  [1:0]  current_scale,
	output reg         usb_five_loads,
	output reg         regulation_voltage,
	output reg         charge_status_a,
	output reg         charge_status_a_oe,
	output reg         charge_status_b,
	output reg         charge_status_b_oe,
	output reg         supply_good_n,
	output reg         supply_good_n_oe,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	localparam NSYNC = 17;
	localparam [3:0] ST_SHUTDOWN = 4'h0;
	localparam [3:0] ST_STANDBY  = 4'h1;
	localparam [3:0] ST_PRECOND  = 4'h2;
	localparam [3:0] ST_CC       = 4'h3;
	localparam [3:0] ST_CV       = 4'h4;
	localparam [3:0] ST_DONE     = 4'h5;
	localparam [3:0] ST_TEMPF    = 4'h6;
	localparam [3:0] ST_TIMERF   = 4'h7;
	localparam [3:0] ST_TEST     = 4'h8;

	// Two-stage synchroniser for every pin flag.
	reg  [NSYNC-1:0] sync1_q;
	reg  [NSYNC-1:0] sync2_q;
	wire [NSYNC-1:0] pins_in = {system_test_req, cell_temp_sense, die_cooled, die_over_temp,
		current_below_term, cell_below_recharge, cell_at_regulation, cell_below_precond,
		cell_present, safety_timer_enable_n, usb_rate_floating, usb_rate_select_pin,
		adapter_set_floating, adapter_current_set_pin, usb_above_cell, adapter_above_cell,
		adapter_supply_in};

	always @(posedge clock) begin
		if (reset) begin
			sync1_q <= {NSYNC{1'b0}};
			sync2_q <= {NSYNC{1'b0}};
		end else if (clock_enable) begin
			sync1_q <= pins_in;
			sync2_q <= sync1_q;
		end
	end

	// USB supply flag held in its own two-stage chain to keep the order of bits below simple.
	reg usb_s1_q;
	reg usb_supply_seen_q;
	always @(posedge clock) begin
		if (reset) begin
			usb_s1_q          <= 1'b0;
			usb_supply_seen_q <= 1'b0;
		end else if (clock_enable) begin
			usb_s1_q          <= usb_supply_in;
			usb_supply_seen_q <= usb_s1_q;
		end
	end

	// Bit order follows the concatenation above, lowest bit last in the list.
	wire ac_ok      = sync2_q[0] & sync2_q[1];
	wire usb_ok_raw = sync2_q[2];
	wire ac_set_hiz = sync2_q[3];
	wire ac_float   = sync2_q[4];
	wire usb_rate   = sync2_q[5];
	wire usb_float  = sync2_q[6];
	wire te_n       = sync2_q[7];
	wire cell_in    = sync2_q[8];
	wire below_pre  = sync2_q[9];
	wire at_reg     = sync2_q[10];
	wire below_rch  = sync2_q[11];
	wire low_cur    = sync2_q[12];
	wire die_hot    = sync2_q[13];
	wire die_cool   = sync2_q[14];
	wire cell_temp_sense_ok   = sync2_q[15];
	wire test_req   = sync2_q[16];

	// Power qualification: each source needs its lockout flag and its headroom flag over
	// the cell, so a qualified source implies both threshold and margin.
	wire usb_ok     = usb_ok_raw & usb_supply_seen_q;                // see R1
	wire power_ok   = ac_ok | usb_ok;                                // see R1, R2, R17
	wire use_ac     = ac_ok;                                         // see R3
	wire disabled   = use_ac ? (ac_set_hiz | ac_float) : usb_float; // see R5, R6

	// Registers written over the bus.
	reg [31:0] control_q;
	wire [1:0] timer_sel = control_q[`CTRL_TIMER_SEL_HI:`CTRL_TIMER_SEL_LO];

	// Period lookup shared by timer and status readback.
	function [15:0] period_sec;
		input [1:0] sel;
		begin
			case (sel)
				`TSEL_4H: period_sec = `HOURS_4_SEC;
				`TSEL_6H: period_sec = `HOURS_6_SEC;
				`TSEL_8H: period_sec = `HOURS_8_SEC;
				default:  period_sec = 16'h0000;
			endcase
		end
	endfunction

	// Sequencer state and timers.
	reg [3:0]  state_q;
	reg [24:0] tick_q;
	reg [15:0] secs_q;
	reg [15:0] filt_q;
	reg        path_gap_q;
	reg        last_ac_q;
	reg        die_hold_q;

	wire timer_on   = ~te_n & (timer_sel != `TSEL_OFF);              // see R8, R9
	wire charging   = (state_q == ST_PRECOND) | (state_q == ST_CC) | (state_q == ST_CV);
	wire suspended  = die_hold_q | ~cell_temp_sense_ok;                        // see R22, R23
	wire expired    = timer_on & (secs_q >= period_sec(timer_sel));
	wire low_done   = (filt_q >= TERM_FILTER_CYC);                   // see R19
	// Idle states and the end of preconditioning restart the count, so each entry to fast charge
	// from standby, preconditioning or done starts from zero, while a temperature fault keeps the count it had.
	wire timer_clear = (state_q == ST_SHUTDOWN) | (state_q == ST_STANDBY) |
		(state_q == ST_DONE) | (state_q == ST_TEST) |
		(state_q == ST_PRECOND && !below_pre);                   // see R14

	// Die overtemperature hysteresis: suspend when hot, release only when cooled.
	always @(posedge clock) begin
		if (reset) begin
			die_hold_q <= 1'b0;
		end else if (clock_enable) begin
			if (die_hot) begin
				die_hold_q <= 1'b1;                              // see R22
			end else if (die_cool) begin
				die_hold_q <= 1'b0;
			end
		end
	end

	// Safety timer: one tick per second, frozen while suspended, cleared in idle states and at the end of preconditioning.
	always @(posedge clock) begin
		if (reset) begin
			tick_q <= 25'd0;
			secs_q <= 16'h0000;
		end else if (clock_enable) begin
			if (timer_clear) begin
				tick_q <= 25'd0;                                 // see R14
				secs_q <= 16'h0000;
			end else if (charging && timer_on && !suspended) begin // see R26, R4
				if (tick_q == SEC_CYCLES - 25'd1) begin
					tick_q <= 25'd0;
					if (secs_q != 16'hffff) begin
						secs_q <= secs_q + 16'h0001;
					end
				end else begin
					tick_q <= tick_q + 25'd1;
				end
			end
		end
	end

	// Termination filter: low current must persist the whole window.
	always @(posedge clock) begin
		if (reset) begin
			filt_q <= 16'h0000;
		end else if (clock_enable) begin
			if (state_q == ST_CV && low_cur && !suspended) begin
				if (!low_done) begin
					filt_q <= filt_q + 16'h0001;             // see R19
				end
			end else begin
				filt_q <= 16'h0000;
			end
		end
	end

	// Main sequencer; power loss wins over every state.
	always @(posedge clock) begin
		if (reset) begin
			state_q <= ST_SHUTDOWN;
		end else if (clock_enable) begin
			if (!power_ok || (use_ac && ac_set_hiz && !ac_float)) begin
				state_q <= ST_SHUTDOWN;                          // see R1, R5, R17
			end else begin
				case (state_q)
					ST_SHUTDOWN: begin
						state_q <= ST_STANDBY;                   // see R2, R17
					end
					ST_STANDBY: begin
						if (test_req && !cell_in) begin
							state_q <= ST_TEST;
						end else if (!disabled && cell_in) begin // see R10
							state_q <= below_pre ? ST_PRECOND : ST_CC; // see R11
						end
					end
					ST_PRECOND, ST_CC, ST_CV: begin
						if (disabled || !cell_in) begin
							state_q <= ST_STANDBY;
						end else if (!cell_temp_sense_ok) begin
							state_q <= ST_TEMPF;                     // see R23
						end else if (state_q == ST_PRECOND) begin
							if (!below_pre) begin
								state_q <= ST_CC;                // see R13
							end
						end else if (state_q == ST_CC) begin
							if (at_reg) begin
								state_q <= ST_CV;                // see R18
							end else if (expired) begin
								state_q <= ST_TIMERF;            // see R15
							end
						end else if (low_done || expired) begin
							state_q <= ST_DONE;                      // see R19, R20
						end
					end
					ST_TEMPF: begin
						if (disabled || !cell_in) begin
							state_q <= ST_STANDBY;
						end else if (cell_temp_sense_ok) begin
							state_q <= at_reg ? ST_CV : (below_pre ? ST_PRECOND : ST_CC);
						end
					end
					ST_DONE: begin
						if (disabled || !cell_in) begin
							state_q <= ST_STANDBY;
						end else if (below_rch) begin
							state_q <= ST_CC;                        // see R21
						end
					end
					ST_TIMERF: begin
						if (disabled || !cell_in) begin
							state_q <= ST_STANDBY;                   // see R16
						end
					end
					ST_TEST: begin
						if (!test_req) begin
							state_q <= ST_STANDBY;
						end
					end
					default: begin
						state_q <= ST_SHUTDOWN;
					end
				endcase
			end
		end
	end

	// Power path: a changed source sees two cycles with both paths open before the new one closes.
	always @(posedge clock) begin
		if (reset) begin
			adapter_path_on <= 1'b0;
			usb_path_on     <= 1'b0;
			path_gap_q      <= 1'b0;
			last_ac_q       <= 1'b0;
			current_scale   <= `ISEL_OFF;
			usb_five_loads  <= 1'b0;
			regulation_voltage <= 1'b0;
		end else if (clock_enable) begin
			last_ac_q <= use_ac;
			path_gap_q <= (last_ac_q != use_ac);                     // see R4
			if ((charging && !suspended) || state_q == ST_TEST) begin
				if (last_ac_q != use_ac || path_gap_q) begin
					adapter_path_on <= 1'b0;                 // see R4
					usb_path_on     <= 1'b0;
				end else begin
					adapter_path_on <= use_ac;               // see R3
					usb_path_on     <= ~use_ac;
				end
			end else begin
				adapter_path_on <= 1'b0;                         // see R20, R22, R23
				usb_path_on     <= 1'b0;
			end
			if (state_q == ST_PRECOND && !suspended) begin
				current_scale <= `ISEL_PRECOND;                  // see R12
			end else if ((charging && !suspended) || state_q == ST_TEST) begin
				current_scale <= `ISEL_FULL;
			end else begin
				current_scale <= `ISEL_OFF;
			end
			usb_five_loads     <= usb_rate;                          // see R7
			regulation_voltage <= (state_q == ST_CV) || (state_q == ST_TEST); // see R18
		end
	end

	// Open-drain status pins: the enable is high while the pin is pulled low.
	always @(posedge clock) begin
		if (reset) begin
			charge_status_a    <= 1'b0;
			charge_status_a_oe <= 1'b0;
			charge_status_b    <= 1'b0;
			charge_status_b_oe <= 1'b0;
			supply_good_n      <= 1'b0;
			supply_good_n_oe   <= 1'b0;
		end else if (clock_enable) begin
			charge_status_a_oe <= charging || state_q == ST_TEST;        // see R24
			charge_status_b_oe <= state_q == ST_DONE || state_q == ST_TEST;
			supply_good_n_oe   <= power_ok;                              // see R25
		end
	end

	// AXI4-Lite slave: address and data taken in either order, one response each.
	reg        aw_have_q;
	reg        w_have_q;
	reg [11:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;

	always @(posedge clock) begin
		if (reset) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			control_q     <= `CTRL_RESET_VALUE;
		end else if (clock_enable) begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_q[11:2] == `REG_CONTROL >> 2) begin
					s_axi_bresp <= 2'h0;
					if (wstrb_q[0]) begin
						control_q[7:0] <= wdata_q[7:0];
					end
				end else if (awaddr_q[11:2] == `REG_STATUS >> 2 ||
					awaddr_q[11:2] == `REG_TIMER >> 2) begin
					s_axi_bresp <= 2'h0;
				end else begin
					s_axi_bresp <= 2'h2;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: status shows state, source and suspend causes.
	always @(posedge clock) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
		end else if (clock_enable) begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				if (s_axi_araddr[11:2] == `REG_CONTROL >> 2) begin
					s_axi_rdata <= {24'h000000, control_q[7:0]};
				end else if (s_axi_araddr[11:2] == `REG_STATUS >> 2) begin
					s_axi_rdata <= {20'h00000, die_hold_q, ~cell_temp_sense_ok, use_ac,
						power_ok, timer_on, expired, low_done, 1'b0, state_q};
				end else if (s_axi_araddr[11:2] == `REG_TIMER >> 2) begin
					s_axi_rdata <= {period_sec(timer_sel), secs_q};
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // charge_seq
`default_nettype wire

// File: rtl/charge_seq_regs.vh
// Constants for the charge cycle sequencer: AXI4-Lite register map, field positions,
// reset values and timing counts.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
//
// How it works
// R1: Shut down on lockout or small headroom.
// R2: Stay off until input exceeds cell.
// R3: Adapter preferred; USB used when adapter absent.
// R4: Break before make; timer keeps counting.
// R5: Current-set pin high impedance shuts down, floating standby.
// R6: Floating USB rate pin stops USB charging.
// R7: USB rate low one load, high five.
// R8: Timer enable low enables, high disables.
// R9: Timer period fixed: off, 4, 6, 8 hours.
// R10: Charge starts only qualified with cell present.
// R11: Low cell starts in preconditioning.
// R12: Preconditioning delivers reduced fixed fraction current.
// R13: Above threshold moves to constant current.
// R14: Constant current entry resets timer.
// R15: Timer expiry in fast charge faults.
// R16: Fault leaves to standby on removal.
// R17: Power loss shuts down; restore restarts sequence.
// R18: Reaching regulation voltage enters constant voltage.
// R19: Low current held 1 ms terminates.
// R20: Termination latches current off, complete state.
// R21: Below recharge threshold restarts cycle.
// R22: Die overtemperature suspends until cooled.
// R23: Cell temperature out of window suspends.
// R24: Status outputs encode charging, complete, test.
// R25: Supply good low when input qualifies.
// R26: Timer counts only while enabled and charging.
`ifndef CHARGE_SEQ_REGS_VH
`define CHARGE_SEQ_REGS_VH

// Register byte offsets.
`define REG_CONTROL     12'h000
`define REG_STATUS      12'h004
`define REG_TIMER       12'h008

// Control register fields.
`define CTRL_TIMER_SEL_LO 0
`define CTRL_TIMER_SEL_HI 1
`define CTRL_HOLD_BIT     2
`define CTRL_RESET_VALUE  32'h00000001

// Safety timer period selections.
`define TSEL_OFF        2'h0
`define TSEL_4H         2'h1
`define TSEL_6H         2'h2
`define TSEL_8H         2'h3

// Time base: one tick per second at 20 MHz.
`define CLOCK_HZ        20000000
`define SEC_CYCLES      25'd20000000
`define HOURS_4_SEC     16'd14400
`define HOURS_6_SEC     16'd21600
`define HOURS_8_SEC     16'd28800

// Termination filter: 1 ms at 20 MHz.
`define TERM_FILTER_US  1000
`define TERM_FILTER_CYC 16'h4e20

// Current scale codes.
`define ISEL_OFF        2'h0
`define ISEL_PRECOND    2'h1
`define ISEL_FULL       2'h2

`endif

// File: dv/charge_seq_props.sv
// Port checks for the charge cycle sequencer.
// Assumes flag inputs hold steady for some cycles around each change.
`default_nettype none
module charge_seq_props (
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       adapter_supply_in,
	input wire logic       usb_supply_in,
	input wire logic       adapter_above_cell,
	input wire logic       adapter_current_set_pin,
	input wire logic       usb_rate_select_pin,
	input wire logic       die_over_temp,
	input wire logic       cell_temp_sense,
	input wire logic       adapter_path_on,
	input wire logic       usb_path_on,
	input wire logic [1:0] current_scale,
	input wire logic       usb_five_loads,
	input wire logic       charge_status_a_oe,
	input wire logic       charge_status_b_oe,
	input wire logic       supply_good_n_oe
);
	// One domain, so clock and reset are shared by every property.
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// Flags cross two synchroniser flops, so a level gets six cycles to act.
	AST_LOCKOUT: assert property ((!adapter_supply_in && !usb_supply_in)[*6]
		|-> !adapter_path_on && !usb_path_on && current_scale == 2'h0)
		else $error("path open without supply");
	AST_ONE_PATH: assert property (!(adapter_path_on && usb_path_on))
		else $error("both paths on");
	AST_ADAPTER_FIRST: assert property ((adapter_supply_in && usb_supply_in)[*8]
		|-> !usb_path_on)
		else $error("usb path with adapter up");
	AST_BREAK_USB: assert property ($fell(usb_path_on) |-> !adapter_path_on [*2])
		else $error("adapter path too soon");
	AST_BREAK_ADAPTER: assert property ($fell(adapter_path_on) |-> !usb_path_on [*2])
		else $error("usb path too soon");
	AST_ENABLE: assert property ((adapter_supply_in && adapter_current_set_pin)[*6]
		|-> current_scale == 2'h0 && !charge_status_a_oe)
		else $error("charging with set pin open");
	AST_USB_RATE: assert property ((usb_path_on && $stable(usb_rate_select_pin))[*6]
		|-> usb_five_loads == usb_rate_select_pin)
		else $error("usb rate wrong");
	AST_DONE_OFF: assert property (charge_status_b_oe && !charge_status_a_oe
		|-> current_scale == 2'h0)
		else $error("current when complete");
	AST_DIE_HOLD: assert property (die_over_temp [*6] |-> current_scale == 2'h0)
		else $error("current with die hot");
	AST_CELL_TEMP_SENSE: assert property ((!cell_temp_sense && !charge_status_b_oe)[*6]
		|-> current_scale == 2'h0)
		else $error("current with cell too hot");
	AST_STATUS_A: assert property (current_scale != 2'h0 |-> charge_status_a_oe)
		else $error("current without status");
	AST_GOOD: assert property ((adapter_supply_in && adapter_above_cell)[*6]
		|-> supply_good_n_oe)
		else $error("supply good missing");

	// Completion, a source hand-over and system test.
	cover property (charge_status_b_oe && !charge_status_a_oe);
	cover property ($fell(usb_path_on) ##[1:8] adapter_path_on);
	cover property (charge_status_a_oe && charge_status_b_oe);
endmodule // charge_seq_props

bind charge_seq charge_seq_props u_charge_seq_props (.*);
`default_nettype wire

// File: dv/cell_supply_model.sv
// Behavioural model of the cell, both supplies and the host pins.
// Assumes the bench changes knob just after a rising clock edge.
`default_nettype none
module cell_supply_model (
	input wire logic        clock,
	input wire logic [15:0] knob,
	input wire logic        regulation_voltage,
	output var logic [17:0] flags
);
	initial flags = 18'h00000;

	// Levels follow the knobs one edge later. A live input stands well above the cell, and
	// the current only tails off under voltage regulation, so that flag is masked outside it.
	always @(posedge clock) begin
		flags <= {knob[1:0], knob[15:12], knob[11] & regulation_voltage, knob[10:0]};
	end
endmodule // cell_supply_model
`default_nettype wire

// File: dv/charge_seq_tb.sv
// Self-checking bench for the charge cycle sequencer.
// Assumes the design header; all comparator flags come from the cell model.
`default_nettype none
`include "charge_seq_regs.vh"
module charge_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, reset, clock_enable, adapter_supply_in, usb_supply_in;
	logic        adapter_above_cell, usb_above_cell, adapter_current_set_pin;
	logic        adapter_set_floating, usb_rate_select_pin, usb_rate_floating;
	logic        safety_timer_enable_n, cell_present, cell_below_precond, cell_at_regulation;
	logic        cell_below_recharge, current_below_term, die_over_temp, die_cooled;
	logic        cell_temp_sense, system_test_req, adapter_path_on, usb_path_on;
	logic        usb_five_loads, regulation_voltage, charge_status_a, charge_status_a_oe;
	logic        charge_status_b, charge_status_b_oe, supply_good_n, supply_good_n_oe;
	logic [1:0]  current_scale, s_axi_bresp, s_axi_rresp, r;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, t1, t2;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [17:0] flags;
	logic [15:0] knob;
	logic [15:0] per [0:3] = '{16'h0000, `HOURS_4_SEC, `HOURS_6_SEC, `HOURS_8_SEC};
	int          miscompares = 0;
	int          n_checks = 0;
	// Rows: knob settings, expected state (f: any), expected scale (3: any).
	logic [21:0] rows [0:15] = '{
		{16'h4080, 4'h0, 2'h0},
		{16'h40a2, 4'h1, 2'h0},
		{16'h4192, 4'h2, 2'h1},
		{16'h4082, 4'h3, 2'h2},
		{16'h4083, 4'h3, 2'h2},
		{16'h4283, 4'h4, 2'h3},
		{16'h4a83, 4'h5, 2'h0},
		{16'h4483, 4'h3, 2'h2},
		{16'h5083, 4'hf, 2'h0},
		{16'h6083, 4'h3, 2'h2},
		{16'h2083, 4'h6, 2'h0},
		{16'h6083, 4'h3, 2'h2},
		{16'h6087, 4'h0, 2'h0},
		{16'h608b, 4'h1, 2'h0},
		{16'he003, 4'h8, 2'h3},
		{16'h0000, 4'h0, 2'h0}
	};

	assign {usb_above_cell, adapter_above_cell, system_test_req, cell_temp_sense, die_cooled,
		die_over_temp, current_below_term, cell_below_recharge, cell_at_regulation,
		cell_below_precond, cell_present, safety_timer_enable_n, usb_rate_floating,
		usb_rate_select_pin, adapter_set_floating, adapter_current_set_pin, usb_supply_in,
		adapter_supply_in} = flags;

	// One cycle per second lets a four-hour period run out within the run, and a short
	// filter keeps the low-current window cheap; the timer fault costs about 14500 cycles.
	charge_seq #(.SEC_CYCLES(25'h0000001), .TERM_FILTER_CYC(16'd5)) u_charge_seq (.*);
	cell_supply_model u_cell_supply_model (.clock(clock), .knob(knob),
		.regulation_voltage(regulation_voltage), .flags(flags));

	// Clock at 20 MHz.
	always #25 clock = ~clock;

	// Counts each comparison; a mismatch is reported at once.
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Write: address and data offered together, each dropped once taken.
	task axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// No cycle count is assumed: only the watchdog ends a wait that never finishes.
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task row_chk(input logic [21:0] w);
		if (w[5:2] != 4'hf) begin
			chk(d[3:0], w[5:2]);
			chk({charge_status_a_oe, charge_status_b_oe}, {w[5:2] inside {4'h2, 4'h3, 4'h4,
				4'h8}, w[5:2] inside {4'h5, 4'h8}});
		end
		if (w[1:0] != 2'h3) chk(current_scale, w[1:0]);
		if (w[1:0] == 2'h2) chk({adapter_path_on, usb_path_on}, {w[6], !w[6]});
		if (w[1:0] != 2'h0 && !w[6]) chk(usb_five_loads, w[10]);
		chk(supply_good_n_oe, w[6] | w[7]);
	endtask

	// Reset, the table of steady cases, then the awkward cases by hand.
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		clock_enable = 1'b1;
		knob = 16'h0000;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		chk({adapter_path_on, usb_path_on, current_scale}, 4'h0);
		axr(`REG_CONTROL, d, r);
		chk(d, `CTRL_RESET_VALUE);
		foreach (rows[i]) begin
			@(posedge clock);
			knob <= rows[i][21:6];
			repeat (20) @(posedge clock);
			axr(`REG_STATUS, d, r);
			row_chk(rows[i]);
		end
		// In regulation with the timer disabled the count must stand still.
		knob <= 16'h42c3;
		repeat (20) @(posedge clock);
		axr(`REG_TIMER, t1, r);
		repeat (40) @(posedge clock);
		axr(`REG_TIMER, t2, r);
		chk(t2[15:0], t1[15:0]);
		knob <= 16'h4283;
		repeat (40) @(posedge clock);
		axr(`REG_TIMER, t2, r);
		chk(t2[15:0] > t1[15:0], 1'b1);
		// A three-cycle low-current blip is shorter than the filter.
		knob <= 16'h4a83;
		repeat (3) @(posedge clock);
		knob <= 16'h4283;
		repeat (20) @(posedge clock);
		axr(`REG_STATUS, d, r);
		chk(d[3:0], 4'h4);
		knob <= 16'h4a83;
		repeat (20) @(posedge clock);
		axr(`REG_STATUS, d, r);
		chk({d[3:0], current_scale}, {4'h5, 2'h0});
		// Recharge re-enters fast charge with the timer held off, so the count must be zero.
		knob <= 16'h44c3;
		repeat (20) @(posedge clock);
		axr(`REG_TIMER, d, r);
		chk(d[15:0], 16'h0000);
		// Unmapped words give a slave error; status ignores writes.
		axw(12'h00c, 32'h3, r);
		chk(r, 2'h2);
		axr(12'h00c, d, r);
		chk({r, d[29:0]}, 32'h80000000);
		axw(`REG_STATUS, 32'hf, r);
		chk(r, 2'h0);
		for (int s = 0; s < 4; s++) begin
			axw(`REG_CONTROL, s, r);
			axr(`REG_TIMER, d, r);
			chk(d[31:16], per[s]);
		end
		// A four-hour period runs out in fast charge; removing the cell leaves the fault.
		axw(`REG_CONTROL, 32'h1, r);
		knob <= 16'h4083;
		repeat (14420) @(posedge clock);
		axr(`REG_STATUS, d, r);
		chk({d[3:0], current_scale}, {4'h7, 2'h0});
		knob <= 16'h4003;
		repeat (20) @(posedge clock);
		axr(`REG_STATUS, d, r);
		chk(d[3:0], 4'h1);
		// A second reset in mid-run restores the control word.
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		chk(current_scale, 2'h0);
		axr(`REG_CONTROL, d, r);
		chk(d, `CTRL_RESET_VALUE);
		test_done;
	end

	// The run needs about 15000 cycles; a hang is cut off here.
	initial begin
		repeat (40000) @(posedge clock);
		miscompares++;
		test_done;
	end
endmodule // charge_seq_tb
`default_nettype wire
